// ### hdl/stl_defines.svh
// Constants of the serial threshold loader: widths, counts and reset values.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef STL_DEFINES_SVH
`define STL_DEFINES_SVH

`define STL_THRESH_WIDTH   8
`define STL_COUNT_WIDTH    3
`define STL_COUNT_LAST     3'h7
`define STL_COUNT_ZERO     3'h0
`define STL_THRESH_RESET   8'h00
`define STL_SHIFT_RESET    8'h00
`define STL_PIN_COUNT      4
`define STL_PIN_SCLK       0
`define STL_PIN_SDATA      1
`define STL_PIN_MODE_P     2
`define STL_PIN_MODE_T     3

`endif

// ### hdl/stl_pkg.sv
// Types of the serial threshold loader.
// Assumes nothing beyond a SystemVerilog compiler.
package stl_pkg;

    // Mode pins, temperature select high bit, pressure select low bit.
    typedef enum logic [1:0] {
        STL_MODE_STANDBY  = 2'b00,
        STL_MODE_PRESSURE = 2'b01,
        STL_MODE_TEMP     = 2'b10,
        STL_MODE_READ     = 2'b11
    } stl_mode_e;

endpackage

// ### hdl/stl_pin_sync.sv
// Pin input conditioner: three flip-flops per pin and an agreement filter.
// Assumes pins are asynchronous to clk and held stable for several clk periods.
`include "stl_defines.svh"

module stl_pin_sync (
    // Clock and reset.
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // Raw pins and their filtered levels.
    input  wire logic [`STL_PIN_COUNT-1:0]     pinIn,
    output logic      [`STL_PIN_COUNT-1:0]     pinLevel
);

    genvar i;
    generate
        for (i = 0; i < `STL_PIN_COUNT; i = i + 1) begin : g_pin
            logic stage1Reg;
            logic stage2Reg;
            logic stage3Reg;
            logic levelReg;
            logic levelNext;

            // The level moves only once the second and third stages agree.
            assign levelNext = (stage2Reg == stage3Reg) ? stage3Reg : levelReg;

            // Synchroniser chain; the first stage feeds only the second.
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    stage1Reg <= 1'b0;
                    stage2Reg <= 1'b0;
                    stage3Reg <= 1'b0;
                    levelReg  <= 1'b0;
                end else begin
                    stage1Reg <= pinIn[i];
                    stage2Reg <= stage1Reg;
                    stage3Reg <= stage2Reg;
                    levelReg  <= levelNext;
                end
            end

            assign pinLevel[i] = levelReg;
        end
    endgenerate

endmodule // stl_pin_sync

// ### hdl/stl_threshold_loader.sv
// Serial loader of the 8-bit comparator threshold, with mode decode and comparator output.
// Assumes a controller drives the serial clock and data pins and both mode pins;
// the held sample arrives as an 8-bit code on the clk domain.
// The pins are slow next to clk, so each passes a three-stage filter before use;
// a pin edge therefore reaches the logic about four clk edges after it happens.
//
// Notes on behaviour
// - Threshold is eight binary-weighted bits, bit zero weight one, bit seven weight 128.
// - Serial data shifts into the shift register on each rising serial clock edge.
// - Eighth falling edge since counter clear copies the shift register into the threshold.
// - Output pin is the comparison of held sample against the threshold in output read mode, high in the other modes.
// - Threshold keeps its value in every mode while powered.
// - Pressure or temperature measure mode clears the bit counter, dropping partial bytes.
// - Reset clears counter and threshold; pulsing a mode pin high also clears the counter.
// - Temperature current source is on only in temperature measure mode.
// - Modes decode 00 standby, 01 pressure, 10 temperature, 11 output read.
`include "stl_defines.svh"

module stl_threshold_loader (
    // Clock and reset.
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    // Serial pins from the controller.
    input  wire logic                           serialClk,
    input  wire logic                           serialData,
    // Mode pins.
    input  wire logic                           mode_select_pressure,
    input  wire logic                           mode_select_temperature,
    // Held sample from the measurement path.
    input  wire logic [`STL_THRESH_WIDTH-1:0]   sampleCode,
    // Threshold, comparator pin and analog enables.
    output logic      [`STL_THRESH_WIDTH-1:0]   comparator_threshold_level,
    output logic                                compareOut,
    output logic                                pressureMeasureEnable,
    output logic                                tempCurrentEnable
);

    // Filtered pin levels and the serial clock edge detector.
    logic [`STL_PIN_COUNT-1:0]   pinLevel;
    logic                        sclkPrevReg;

    // Serial shift register, threshold register and bit counter.
    logic [`STL_THRESH_WIDTH-1:0] shiftReg;
    logic [`STL_THRESH_WIDTH-1:0] shiftNext;
    logic [`STL_THRESH_WIDTH-1:0] thresholdReg;
    logic [`STL_THRESH_WIDTH-1:0] thresholdNext;
    logic [`STL_COUNT_WIDTH-1:0]  countReg;
    logic [`STL_COUNT_WIDTH-1:0]  countNext;

    // Registered pin and enable outputs.
    logic                        compareReg;
    logic                        compareNext;
    logic                        pressEnReg;
    logic                        tempEnReg;

    // Decoded mode and the strobes derived from the filtered pins.
    stl_pkg::stl_mode_e          mode;
    wire                         sclkLevel;
    wire                         dataLevel;
    wire                         sclkRise;
    wire                         sclkFall;
    wire                         counterClear;
    wire                         byteDone;
    wire                         sampleAbove;

    // Serial clock and data share one filter latency, so data set up ahead of a
    // rising serial clock edge is already settled when that edge is seen.
    // Conditions every pin through the three-stage filter.
    stl_pin_sync u_pin_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .pinIn    ({mode_select_temperature, mode_select_pressure, serialData, serialClk}),
        .pinLevel (pinLevel)
    );

    // The edge detector starts low, the idle level of the serial clock, so no
    // false edge follows reset. Both mode pins share one latency, so a change
    // of both at once passes through no intermediate mode.
    // Filtered levels, edges and mode decode.
    assign sclkLevel    = pinLevel[`STL_PIN_SCLK];
    assign dataLevel    = pinLevel[`STL_PIN_SDATA];
    assign mode         = stl_pkg::stl_mode_e'({pinLevel[`STL_PIN_MODE_T],
                                                pinLevel[`STL_PIN_MODE_P]});
    assign sclkRise     = sclkLevel & ~sclkPrevReg;
    assign sclkFall     = ~sclkLevel & sclkPrevReg;
    assign counterClear = (mode == stl_pkg::STL_MODE_PRESSURE) ||
                          (mode == stl_pkg::STL_MODE_TEMP);
    assign byteDone     = sclkFall && !counterClear && (countReg == `STL_COUNT_LAST);

    // Shift in MSB first on rising edges; the byte moves over on the eighth fall.
    assign shiftNext     = sclkRise ? {shiftReg[`STL_THRESH_WIDTH-2:0], dataLevel}
                                    : shiftReg;
    assign thresholdNext = byteDone ? shiftReg : thresholdReg;

    // A clear in a measure mode wins over a falling edge, so a corrupted stream is
    // always dropped whole; the counter wraps after a transfer so that bytes may
    // follow back to back.
    // Counter counts falls, wraps after a transfer, and is held clear in measure modes.
    assign countNext = counterClear ? `STL_COUNT_ZERO :
                       byteDone     ? `STL_COUNT_ZERO :
                       sclkFall     ? 3'(countReg + 3'h1) : countReg;

    // The comparison is strict: a sample equal to the threshold reads low, and the
    // threshold keeps its value across all modes, so only a new byte moves it.
    // Unsigned binary comparison; the pin idles high outside output read.
    assign sampleAbove = (sampleCode > thresholdReg);
    assign compareNext = (mode == stl_pkg::STL_MODE_READ) ? sampleAbove : 1'b1;

    // Reset gives the counter and threshold a known start for the controller.
    // The controller may still clear the counter with a mode pulse before loading.
    // Serial capture state.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclkPrevReg  <= 1'b0;
            shiftReg     <= `STL_SHIFT_RESET;
            thresholdReg <= `STL_THRESH_RESET;
            countReg     <= `STL_COUNT_ZERO;
        end else begin
            sclkPrevReg  <= sclkLevel;
            shiftReg     <= shiftNext;
            thresholdReg <= thresholdNext;
            countReg     <= countNext;
        end
    end

    // Registering them keeps the pins free of decode glitches while mode pins move.
    // Registered outputs driven from the decoded mode.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compareReg <= 1'b1;
            pressEnReg <= 1'b0;
            tempEnReg  <= 1'b0;
        end else begin
            compareReg <= compareNext;
            pressEnReg <= (mode == stl_pkg::STL_MODE_PRESSURE);
            tempEnReg  <= (mode == stl_pkg::STL_MODE_TEMP);
        end
    end

    // Outputs straight from their flip-flops.
    assign comparator_threshold_level = thresholdReg;
    assign compareOut                 = compareReg;
    assign pressureMeasureEnable      = pressEnReg;
    assign tempCurrentEnable          = tempEnReg;

    // Checks on the loader next to the logic.
    // Each check is disabled in reset; the pins reach the logic only through the
    // filter, so all of them are written against the filtered levels.
    chk_shift_sample: assert property (@(posedge clk) disable iff (!rst_n)
        sclkRise |=> shiftReg == {$past(shiftReg[6:0]), $past(dataLevel)})
        else $error("Shift register missed a rising edge sample.");

    chk_byte_transfer: assert property (@(posedge clk) disable iff (!rst_n)
        byteDone |=> comparator_threshold_level == $past(shiftReg))
        else $error("Threshold was not loaded on the eighth falling edge.");

    chk_count_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        byteDone |=> countReg == 3'h0 ##1 (countReg == 3'h0 || $past(sclkFall)))
        else $error("Bit counter did not restart after a transfer.");

    chk_count_clear: assert property (@(posedge clk) disable iff (!rst_n)
        counterClear ##1 counterClear |-> countReg == 3'h0 && $stable(thresholdReg))
        else $error("Counter not held clear in a measure mode.");

    chk_hold_value: assert property (@(posedge clk) disable iff (!rst_n)
        !byteDone |=> $stable(comparator_threshold_level))
        else $error("Threshold changed without a completed byte.");

    chk_temp_source: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 tempCurrentEnable == ($past(mode) == stl_pkg::STL_MODE_TEMP))
        else $error("Temperature current source enable is wrong for the mode.");

    chk_compare_read: assert property (@(posedge clk) disable iff (!rst_n)
        mode == stl_pkg::STL_MODE_READ |=>
            compareOut == ($past(sampleCode) > $past(thresholdReg)))
        else $error("Comparator output does not follow sample versus threshold.");

    chk_msb_weight: assert property (@(posedge clk) disable iff (!rst_n)
        mode == stl_pkg::STL_MODE_READ && sampleCode[7] && !thresholdReg[7] |=> compareOut)
        else $error("Bit seven does not carry the largest weight.");

    chk_standby_high: assert property (@(posedge clk) disable iff (!rst_n)
        mode != stl_pkg::STL_MODE_READ |=> compareOut)
        else $error("Output pin not high outside output read mode.");

    chk_press_enable: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 pressureMeasureEnable == ($past(mode) == stl_pkg::STL_MODE_PRESSURE))
        else $error("Pressure measure enable is wrong for the mode.");

    chk_clear_entry: assert property (@(posedge clk) disable iff (!rst_n)
        counterClear |=> countReg == 3'h0)
        else $error("Bit counter not cleared by a measure mode.");

    chk_count_step: assert property (@(posedge clk) disable iff (!rst_n)
        sclkFall && !counterClear && !byteDone |=> countReg == $past(countReg) + 3'h1)
        else $error("Bit counter missed a falling edge.");

    chk_fall_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !sclkFall && !counterClear |=> $stable(countReg))
        else $error("Bit counter moved without a falling edge.");

    chk_shift_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !sclkRise |=> $stable(shiftReg))
        else $error("Shift register moved without a rising edge.");

    chk_read_low: assert property (@(posedge clk) disable iff (!rst_n)
        mode == stl_pkg::STL_MODE_READ && sampleCode <= thresholdReg |=> !compareOut)
        else $error("Output pin high with the sample not above the threshold.");

    chk_lsb_weight: assert property (@(posedge clk) disable iff (!rst_n)
        mode == stl_pkg::STL_MODE_READ && thresholdReg != 8'hff &&
            sampleCode == thresholdReg + 8'h01 |=> compareOut)
        else $error("Bit zero does not carry a weight of one.");

    chk_read_enables: assert property (@(posedge clk) disable iff (!rst_n)
        mode == stl_pkg::STL_MODE_READ |=> !pressureMeasureEnable && !tempCurrentEnable)
        else $error("A measure enable is on in output read mode.");

endmodule // stl_threshold_loader

// ### verif/stl_ctrl_model.sv
// Controller model driving the serial and mode pins of the threshold loader.
// Assumes a 100 ns clk; the serial clock runs at 800 ns and stands low between bytes.
module stl_ctrl_model (
    // Clock.
    input  wire logic clk,
    // Pins toward the loader.
    output logic      serialClk,
    output logic      serialData,
    output logic      modeP,
    output logic      modeT
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle pins at time zero.
    initial begin
        {serialClk, serialData, modeP, modeT} = 4'h0;
    end

    // Lets n clk edges pass, then steps just after the last one.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Sets the mode pins with the serial lines idle.
    task automatic setMode(input logic [1:0] m);
        tick(1);
        {modeT, modeP} = m;
        tick(8);
    endtask

    // Shifts the top n bits of a byte, first bit first; data falls to its pull-down after.
    task automatic sendBits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            serialData = b[i];
            tick(4);
            serialClk = 1'b1;
            tick(4);
            serialClk = 1'b0;
        end
        serialData = 1'b0;
        tick(4);
    endtask
endmodule // stl_ctrl_model

// ### verif/serial_threshold_loader_tb_top.sv
// Self-checking bench of the threshold loader with a controller model.
// Assumes a 100 ns clk; expected thresholds are queued and matched as they appear.
`include "stl_defines.svh"

module serial_threshold_loader_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                         clk, rst_n, compareOut, pEn, tEn, sClk, sData, mP, mT;
    logic [`STL_THRESH_WIDTH-1:0] sampleCode, level, prevLevel, v, last;
    logic [`STL_THRESH_WIDTH-1:0] expQ[$];
    logic [`STL_THRESH_WIDTH-1:0] heldCode, approx, trial;
    logic [1:0]                   m;
    int                           fails = 0;
    int                           tests_run = 0;
    int                           cycles = 0;

    stl_ctrl_model ctrl_u (.clk(clk), .serialClk(sClk), .serialData(sData),
        .modeP(mP), .modeT(mT));
    stl_threshold_loader dut_u (.clk(clk), .rst_n(rst_n), .serialClk(sClk),
        .serialData(sData), .mode_select_pressure(mP), .mode_select_temperature(mT),
        .sampleCode(sampleCode), .comparator_threshold_level(level),
        .compareOut(compareOut), .pressureMeasureEnable(pEn), .tempCurrentEnable(tEn));

    // Clock at 10 MHz.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Counts a comparison and reports a mismatch.
    task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Queues the expected threshold, then shifts the byte in.
    task automatic load(input logic [7:0] b);
        if (b !== last) expQ.push_back(b); // A repeat of the held value shows no change.
        ctrl_u.sendBits(b, 8);
        repeat (8) @(posedge clk);
        last = b;
    endtask

    // Takes the oldest note whenever the threshold changes; a change without one fails.
    // Looks on the falling clk edge, where the threshold has settled.
    always @(negedge clk) begin
        if (rst_n === 1'b1 && level !== prevLevel) begin
            if (expQ.size() == 0) check("unexpected threshold", prevLevel, level);
            else check("threshold", expQ.pop_front(), level);
        end
        prevLevel <= level;
    end

    // Cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            summarize();
        end
    end

    // Main sequence.
    initial begin
        rst_n = 1'b0;
        sampleCode = 8'h00;
        last = 8'h00;
        void'($urandom(32'hb68c));
        repeat (10) @(posedge clk);
        check("reset threshold", 8'h00, level);
        check("reset enables", 8'h01, {5'h00, tEn, pEn, compareOut});
        #1 rst_n = 1'b1;
        repeat (5) @(posedge clk);
        m = ($urandom_range(0, 1) == 1) ? 2'b10 : 2'b01;
        ctrl_u.setMode(m);
        check("pulse enables", {6'h00, m}, {6'h00, tEn, pEn});
        ctrl_u.setMode(2'b00);
        for (int i = 0; i < 6; i++) begin
            do v = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : 8'($urandom); while (v === last);
            load(v);
        end
        ctrl_u.sendBits(8'($urandom), int'($urandom_range(1, 7)));
        ctrl_u.setMode(2'b10);
        check("temp enables", 8'h02, {6'h00, tEn, pEn});
        ctrl_u.setMode(2'b00);
        check("standby enables", 8'h00, {6'h00, tEn, pEn});
        load(~last);
        ctrl_u.setMode(2'b11);
        for (int i = 0; i < 10; i++) begin
            if (i == 5) load(8'h00);
            @(posedge clk);
            #1 sampleCode = (i % 5 == 0) ? last : (i % 5 == 1) ? last + 8'h01 : 8'($urandom);
            repeat (3) @(posedge clk);
            #1 check("compare", {7'h00, sampleCode > last}, {7'h00, compareOut});
        end
        m = ($urandom_range(0, 1) == 1) ? 2'b10 : 2'b01;
        ctrl_u.setMode(m);
        check("remeasure enables", {6'h00, m}, {6'h00, tEn, pEn});
        check("measure pin", 8'h01, {7'h00, compareOut});
        ctrl_u.setMode(2'b11);
        heldCode = 8'($urandom);
        sampleCode = heldCode;
        approx = 8'h00;
        for (int b = 7; b >= 0; b--) begin
            trial = approx | (8'h01 << b);
            load(trial);
            #1 check("trial", {7'h00, heldCode > trial}, {7'h00, compareOut});
            if (compareOut === 1'b1) approx = trial;
        end
        check("conversion", (heldCode == 8'h00) ? 8'h00 : heldCode - 8'h01, approx);
        m = m ^ 2'b11;
        ctrl_u.setMode(m);
        check("final enables", {6'h00, m}, {6'h00, tEn, pEn});
        repeat (10) @(posedge clk);
        check("pending loads", 8'h00, 8'(expQ.size()));
        summarize();
    end
endmodule // serial_threshold_loader_tb_top
